/* File: rtl/cfg_access_pkg.sv */
`default_nettype none
package cfg_access_pkg;

	// ------------------------------------------------------------
	// Token codes
	// ------------------------------------------------------------
	localparam logic [7:0] TOK_WRITE = 8'h00_C0;
	localparam logic [7:0] TOK_READ  = 8'h00_C1;
	localparam logic [7:0] TOK_END   = 8'h00_01;
	localparam logic [7:0] TOK_ACK   = 8'h00_03;
	localparam logic [7:0] TOK_NACK  = 8'h00_04;

	// ------------------------------------------------------------
	// Field widths and markers
	// ------------------------------------------------------------
	localparam int         RET_BYTES   = 3;
	localparam int         REG_BYTES   = 2;
	localparam int         DATA_BYTES  = 4;
	localparam logic [7:0] NO_REPLY_LO = 8'h00_FF;

	// ------------------------------------------------------------
	// Processor status resource identifier
	// ------------------------------------------------------------
	localparam int          PS_SHIFT = 8;
	localparam logic [31:0] PS_TYPE  = 32'h0000_000B;

	// ------------------------------------------------------------
	// Register file size and reset value
	// ------------------------------------------------------------
	localparam int          NUM_REGS   = 16;
	localparam logic [31:0] REG_RESET  = 32'h0000_0000;

	// ------------------------------------------------------------
	// Link token carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic       ctrl;
		logic [7:0] data;
	} token_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_RET  = 7'b000_0010,
		ST_REG  = 7'b000_0100,
		ST_DATA = 7'b000_1000,
		ST_END  = 7'b001_0000,
		ST_RESP = 7'b010_0000,
		ST_SKIP = 7'b100_0000
	} rx_state_t;

endpackage
`default_nettype wire

/* File: rtl/byte_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
// Shifts a word out MSB-first one byte per accepted beat
module byte_serializer
(
	input  wire logic        mclk,   // Clock
	input  wire logic        rstn,   // Async reset, low
	input  wire logic        load,   // Load word
	input  wire logic [31:0] word,   // Word to send
	input  wire logic        adv,    // Byte consumed
	output logic [7:0]       byte_o  // Current byte
);

	logic [31:0] sh_reg;

	// ------------------------------------------------------------
	// Shifter
	// ------------------------------------------------------------
	// Top byte always presented first
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			sh_reg <= 32'h0000_0000;
		else if (load)
			sh_reg <= word;
		else if (adv)
			sh_reg <= {sh_reg[23:0], 8'h00};
	end

	assign byte_o = sh_reg[31:24];

endmodule
`default_nettype wire

/* File: rtl/cfg_endpoint.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Return id low byte all ones on write means no reply is sent.
// - Multi-byte fields travel most significant byte first.
// - Write reply: tokens 3,1 on success; tokens 4,1 on failure.
// - Read reply: token 3, four data bytes, token 1; failure tokens 4,1.
// - Status read and write move one full 32-bit word.
module cfg_endpoint
(
	input  wire logic                  mclk,      // Clock
	input  wire logic                  rstn,      // Async reset, low
	input  wire cfg_access_pkg::token_t rx_tok,   // Incoming token
	input  wire logic                  rx_valid,  // Incoming token valid
	output logic                       rx_ready,  // Incoming token taken
	output cfg_access_pkg::token_t     tx_tok,    // Reply token
	output logic                       tx_valid,  // Reply token valid
	input  wire logic                  tx_ready,  // Reply token taken
	output logic [23:0]                reply_dest,// Return channel end
	input  wire logic [15:0]           ps_num,    // Status register number
	output logic [31:0]                ps_resid,  // Status resource id
	input  wire logic                  ps_we,     // Status write strobe
	input  wire logic [31:0]           ps_wdata,  // Status write word
	output logic [31:0]                ps_rdata   // Status read word
);

	cfg_access_pkg::rx_state_t state_reg;
	logic [23:0] ret_reg;
	logic [15:0] regn_reg;
	logic [31:0] data_reg;
	logic        is_wr_reg;
	logic [1:0]  cnt_reg;
	logic [2:0]  rsp_reg;
	logic [2:0]  rsp_len_reg;
	logic        ok_reg;
	logic [31:0] regs [cfg_access_pkg::NUM_REGS];
	logic [7:0]  ser_byte;
	logic        take;
	logic        tx_fire;
	logic        hit;
	logic        fire;

	assign rx_ready = (state_reg != cfg_access_pkg::ST_RESP);
	assign take     = rx_valid & rx_ready;
	assign tx_fire  = tx_valid & tx_ready;
	assign hit      = (regn_reg < 16'(cfg_access_pkg::NUM_REGS));
	// Closing token in the right place triggers the access
	assign fire     = take & (state_reg == cfg_access_pkg::ST_END) &
	                  rx_tok.ctrl & (rx_tok.data == cfg_access_pkg::TOK_END);

	// ------------------------------------------------------------
	// Request parser
	// ------------------------------------------------------------
	// Malformed input skips to the next closing token
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= cfg_access_pkg::ST_IDLE;
			cnt_reg   <= 2'd0;
			is_wr_reg <= 1'b0;
			ret_reg   <= 24'h00_0000;
			regn_reg  <= 16'h0000;
			data_reg  <= 32'h0000_0000;
		end
		else
		begin
			case (state_reg)
				cfg_access_pkg::ST_IDLE:
					if (take)
					begin
						cnt_reg <= 2'd0;
						if (rx_tok.ctrl && (rx_tok.data == cfg_access_pkg::TOK_WRITE ||
						                    rx_tok.data == cfg_access_pkg::TOK_READ))
						begin
							is_wr_reg <= (rx_tok.data == cfg_access_pkg::TOK_WRITE);
							state_reg <= cfg_access_pkg::ST_RET;
						end
						else if (!(rx_tok.ctrl && rx_tok.data == cfg_access_pkg::TOK_END))
							state_reg <= cfg_access_pkg::ST_SKIP;
					end
				cfg_access_pkg::ST_RET:
					if (take)
					begin
						// Early closing token ends the message so the next one is not eaten
						if (rx_tok.ctrl)
							state_reg <= (rx_tok.data == cfg_access_pkg::TOK_END) ?
							             cfg_access_pkg::ST_IDLE : cfg_access_pkg::ST_SKIP;
						else
						begin
							ret_reg <= {ret_reg[15:0], rx_tok.data};
							cnt_reg <= cnt_reg + 2'd1;
							if (cnt_reg == 2'(cfg_access_pkg::RET_BYTES - 1))
							begin
								cnt_reg   <= 2'd0;
								state_reg <= cfg_access_pkg::ST_REG;
							end
						end
					end
				cfg_access_pkg::ST_REG:
					if (take)
					begin
						if (rx_tok.ctrl)
							state_reg <= (rx_tok.data == cfg_access_pkg::TOK_END) ?
							             cfg_access_pkg::ST_IDLE : cfg_access_pkg::ST_SKIP;
						else
						begin
							regn_reg <= {regn_reg[7:0], rx_tok.data};
							cnt_reg  <= cnt_reg + 2'd1;
							if (cnt_reg == 2'(cfg_access_pkg::REG_BYTES - 1))
							begin
								cnt_reg   <= 2'd0;
								state_reg <= is_wr_reg ? cfg_access_pkg::ST_DATA
								                       : cfg_access_pkg::ST_END;
							end
						end
					end
				cfg_access_pkg::ST_DATA:
					if (take)
					begin
						if (rx_tok.ctrl)
							state_reg <= (rx_tok.data == cfg_access_pkg::TOK_END) ?
							             cfg_access_pkg::ST_IDLE : cfg_access_pkg::ST_SKIP;
						else
						begin
							data_reg <= {data_reg[23:0], rx_tok.data};
							cnt_reg  <= cnt_reg + 2'd1;
							if (cnt_reg == 2'(cfg_access_pkg::DATA_BYTES - 1))
								state_reg <= cfg_access_pkg::ST_END;
						end
					end
				cfg_access_pkg::ST_END:
					if (take)
					begin
						if (fire)
						begin
							// Suppressed reply only applies to writes
							if (is_wr_reg && ret_reg[7:0] == cfg_access_pkg::NO_REPLY_LO)
								state_reg <= cfg_access_pkg::ST_IDLE;
							else
								state_reg <= cfg_access_pkg::ST_RESP;
						end
						else
							state_reg <= cfg_access_pkg::ST_SKIP;
					end
				cfg_access_pkg::ST_RESP:
					if (tx_fire && rsp_reg == rsp_len_reg - 3'd1)
						state_reg <= cfg_access_pkg::ST_IDLE;
				cfg_access_pkg::ST_SKIP:
					if (take && rx_tok.ctrl && rx_tok.data == cfg_access_pkg::TOK_END)
						state_reg <= cfg_access_pkg::ST_IDLE;
				default:
					state_reg <= cfg_access_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Network writes win over status writes in the same cycle, even to another word
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < cfg_access_pkg::NUM_REGS; i++)
				regs[i] <= cfg_access_pkg::REG_RESET;
		end
		else if (fire && is_wr_reg && hit)
			regs[regn_reg[3:0]] <= data_reg;
		else if (ps_we && ps_num < 16'(cfg_access_pkg::NUM_REGS))
			regs[ps_num[3:0]] <= ps_wdata;
	end

	// Status side: full word, unmapped numbers read zero
	assign ps_rdata = (ps_num < 16'(cfg_access_pkg::NUM_REGS)) ? regs[ps_num[3:0]]
	                                                           : 32'h0000_0000;
	assign ps_resid = ({16'h0000, ps_num} << cfg_access_pkg::PS_SHIFT) |
	                  cfg_access_pkg::PS_TYPE;

	// ------------------------------------------------------------
	// Reply sequencer
	// ------------------------------------------------------------
	// Reply length fixed at the closing token
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_reg     <= 3'd0;
			rsp_len_reg <= 3'd2;
			ok_reg      <= 1'b0;
			reply_dest  <= 24'h00_0000;
		end
		else if (fire)
		begin
			rsp_reg     <= 3'd0;
			ok_reg      <= hit;
			rsp_len_reg <= (hit && !is_wr_reg) ? 3'(cfg_access_pkg::DATA_BYTES + 2) : 3'd2;
			reply_dest  <= ret_reg;
		end
		else if (tx_fire)
			rsp_reg <= rsp_reg + 3'd1;
	end

	byte_serializer u_ser
	(
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (fire),
		.word   (hit ? regs[regn_reg[3:0]] : 32'h0000_0000),
		.adv    (tx_fire && state_reg == cfg_access_pkg::ST_RESP &&
		         rsp_reg != 3'd0),
		.byte_o (ser_byte)
	);

	// Token choice per reply beat
	always_comb
	begin
		tx_valid     = (state_reg == cfg_access_pkg::ST_RESP);
		tx_tok.ctrl  = 1'b1;
		tx_tok.data  = cfg_access_pkg::TOK_END;
		if (rsp_reg == 3'd0)
			tx_tok.data = ok_reg ? cfg_access_pkg::TOK_ACK : cfg_access_pkg::TOK_NACK;
		else if (rsp_reg != rsp_len_reg - 3'd1)
		begin
			tx_tok.ctrl = 1'b0;
			tx_tok.data = ser_byte;
		end
	end

endmodule
`default_nettype wire

/* File: bench/cfg_endpoint_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Endpoint port checks
// ----------------------------------------
module cfg_endpoint_checker
(
	input wire logic                   mclk,       // Clock
	input wire logic                   rstn,       // Reset, low
	input wire cfg_access_pkg::token_t rx_tok,     // Token in
	input wire logic                   rx_valid,   // Token in valid
	input wire logic                   rx_ready,   // Token in taken
	input wire cfg_access_pkg::token_t tx_tok,     // Reply token
	input wire logic                   tx_valid,   // Reply valid
	input wire logic                   tx_ready,   // Reply taken
	input wire logic [23:0]            reply_dest, // Return id
	input wire logic [15:0]            ps_num,     // Status number
	input wire logic [31:0]            ps_resid,   // Status id
	input wire logic                   ps_we,      // Status write
	input wire logic [31:0]            ps_wdata,   // Status data
	input wire logic [31:0]            ps_rdata    // Status read
);
	logic end_taken;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Closing token accepted; a reply may only follow this
	assign end_taken = rx_valid && rx_ready && rx_tok == {1'b1, cfg_access_pkg::TOK_END};

	resid_map_a: assert property (ps_resid == {8'h00, ps_num, 8'h0B})
		else $error("status id mismatch");
	reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_tok))
		else $error("reply token dropped while stalled");
	busy_refuse_a: assert property (tx_valid |-> !rx_ready)
		else $error("token taken during reply");
	reply_start_a: assert property ($rose(tx_valid) |-> tx_tok.ctrl &&
		(tx_tok.data == cfg_access_pkg::TOK_ACK || tx_tok.data == cfg_access_pkg::TOK_NACK))
		else $error("reply opens with wrong token");
	reply_cause_a: assert property ($rose(tx_valid) |-> $past(end_taken))
		else $error("reply without closing token");
	fail_close_a: assert property (tx_valid && tx_ready && tx_tok == {1'b1,
		cfg_access_pkg::TOK_NACK} |=> tx_valid && tx_tok == {1'b1, cfg_access_pkg::TOK_END})
		else $error("failure not closed");
	reply_last_a: assert property (tx_valid && tx_ready &&
		tx_tok == {1'b1, cfg_access_pkg::TOK_END} |=> !tx_valid && rx_ready)
		else $error("reply runs past closing token");
	status_word_a: assert property (ps_we && ps_num < cfg_access_pkg::NUM_REGS &&
		!rx_valid ##1 !rx_valid && $stable(ps_num) |-> ps_rdata == $past(ps_wdata))
		else $error("status word not stored whole");
endmodule
`default_nettype wire

/* File: bench/cfg_requester.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Requesting channel end model
// ----------------------------------------
module cfg_requester
(
	input wire logic                   mclk,     // Clock
	input wire logic                   rx_ready, // Endpoint takes token
	input wire cfg_access_pkg::token_t tx_tok,   // Reply token
	input wire logic                   tx_valid, // Reply valid
	output var cfg_access_pkg::token_t rx_tok,   // Request token
	output var logic                   rx_valid, // Request valid
	output var logic                   tx_ready  // Reply taken
);
	// Idle bus at time zero
	initial
	begin
		rx_tok = '0;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// Hold one token until the edge that sees ready
	task put(input cfg_access_pkg::token_t t);
		rx_tok <= t;
		rx_valid <= 1'b1;
		@(negedge mclk);
		for (int i = 0; i < 40 && !rx_ready; i++) @(negedge mclk);
		@(posedge mclk);
	endtask

	// Whole message; fields leave top byte first
	// Channel already routed to the tile or node endpoint suffix
	task request(input logic wr, input logic [23:0] ret, input logic [15:0] num,
		input logic [31:0] dat);
		logic [71:0] msg;
		msg = {ret, num, dat};
		@(posedge mclk);
		tx_ready <= 1'b0; // Park reply ready until a beat is wanted
		put({1'b1, wr ? cfg_access_pkg::TOK_WRITE : cfg_access_pkg::TOK_READ});
		for (int i = 0; i < (wr ? 9 : 5); i++)
			put({1'b0, msg[71 - 8 * i -: 8]});
		put({1'b1, cfg_access_pkg::TOK_END});
		rx_valid <= 1'b0;
		// Released bus shows junk, not the last token
		rx_tok <= cfg_access_pkg::token_t'(~rx_tok);
	endtask

	// Stray byte, then a write header cut short by a closing token
	task cut(input int n);
		@(posedge mclk);
		put({1'b0, 8'h5A});
		put({1'b1, cfg_access_pkg::TOK_END});
		put({1'b1, cfg_access_pkg::TOK_WRITE});
		for (int i = 0; i < n; i++)
			put({1'b0, 8'h5A});
		put({1'b1, cfg_access_pkg::TOK_END});
		rx_valid <= 1'b0;
	endtask

	// Take one reply beat, stalling first
	// Ready stays up after a beat, so back-to-back beats never drive it twice in one step
	task take(input int stall, output cfg_access_pkg::token_t t);
		if (stall > 0)
		begin
			tx_ready <= 1'b0;
			repeat (stall) @(posedge mclk);
		end
		tx_ready <= 1'b1;
		@(negedge mclk);
		for (int i = 0; i < 40 && !tx_valid; i++) @(negedge mclk);
		t = tx_tok;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Endpoint testbench
// ----------------------------------------
module testbench;
	localparam logic [8:0] ACK  = {1'b1, cfg_access_pkg::TOK_ACK};
	localparam logic [8:0] NACK = {1'b1, cfg_access_pkg::TOK_NACK};
	localparam logic [8:0] FIN  = {1'b1, cfg_access_pkg::TOK_END};

	logic                   mclk = 1'b0;
	logic                   rstn = 1'b0;
	cfg_access_pkg::token_t rx_tok;
	cfg_access_pkg::token_t tx_tok;
	logic                   rx_valid, rx_ready, tx_valid, tx_ready;
	logic [23:0]            reply_dest;
	logic [15:0]            ps_num = 16'h0000;
	logic [31:0]            ps_resid, ps_rdata;
	logic                   ps_we = 1'b0;
	logic [31:0]            ps_wdata = 32'h0000_0000;
	int                     num_errors = 0;
	int                     compares = 0;

	cfg_endpoint dut_u (.mclk(mclk), .rstn(rstn), .rx_tok(rx_tok), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_tok(tx_tok), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.reply_dest(reply_dest), .ps_num(ps_num), .ps_resid(ps_resid), .ps_we(ps_we),
		.ps_wdata(ps_wdata), .ps_rdata(ps_rdata));
	cfg_requester req_u (.mclk(mclk), .rx_ready(rx_ready), .tx_tok(tx_tok),
		.tx_valid(tx_valid), .rx_tok(rx_tok), .rx_valid(rx_valid), .tx_ready(tx_ready));

	// 50 MHz clock
	always #10 mclk = ~mclk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Compare n reply beats in order
	task reply(input int n, input int stall, input logic [8:0] e [6]);
		cfg_access_pkg::token_t t;
		for (int i = 0; i < n; i++)
		begin
			req_u.take(stall, t);
			check(32'(t), 32'(e[i]));
		end
	endtask

	task t_write;
		req_u.request(1'b1, 24'h12_3456, 16'h0003, 32'hA5B6_C7D8);
		reply(2, 0, '{ACK, FIN, 0, 0, 0, 0});
		check(32'(reply_dest), 32'h0012_3456);
		req_u.request(1'b0, 24'h65_4321, 16'h0003, 32'h0000_0000);
		reply(6, 2, '{ACK, 9'h0A5, 9'h0B6, 9'h0C7, 9'h0D8, FIN});
		$display("write and read test done");
	endtask

	// Suppressed reply, then seen through the status port
	task t_silent;
		logic seen;
		seen = 1'b0;
		req_u.request(1'b1, 24'h00_12FF, 16'h0005, 32'h0102_0304);
		repeat (10) @(negedge mclk) seen |= tx_valid;
		check(32'(seen), 32'h0000_0000);
		@(posedge mclk);
		ps_num <= 16'h0005;
		@(negedge mclk);
		check(ps_rdata, 32'h0102_0304);
		check(ps_resid, 32'h0000_050B);
		$display("silent write test done");
	endtask

	task t_status;
		@(posedge mclk);
		ps_num <= 16'h000F;
		ps_we <= 1'b1;
		ps_wdata <= 32'hDEAD_BEEF;
		@(posedge mclk);
		ps_we <= 1'b0;
		req_u.request(1'b0, 24'h00_0A00, 16'h000F, 32'h0000_0000);
		reply(6, 0, '{ACK, 9'h0DE, 9'h0AD, 9'h0BE, 9'h0EF, FIN});
		$display("status write test done");
	endtask

	// Unimplemented numbers must fail both ways
	task t_fail;
		req_u.request(1'b1, 24'h00_3300, 16'h0100, 32'h1111_2222);
		reply(2, 1, '{NACK, FIN, 0, 0, 0, 0});
		req_u.request(1'b0, 24'h00_3300, 16'h0010, 32'h0000_0000);
		reply(2, 0, '{NACK, FIN, 0, 0, 0, 0});
		$display("failure test done");
	endtask

	// Cut message must not swallow the read that follows it
	task t_cut;
		req_u.cut(2);
		req_u.request(1'b0, 24'h00_4400, 16'h0000, 32'h0000_0000);
		reply(6, 0, '{ACK, 9'h000, 9'h000, 9'h000, 9'h000, FIN});
		$display("cut message test done");
	endtask

	task give_verdict;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		t_write;
		t_silent;
		t_status;
		t_fail;
		t_cut;
		give_verdict;
	end

	// Watchdog well past the expected run
	initial
	begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		give_verdict;
	end
endmodule

bind cfg_endpoint cfg_endpoint_checker chk_u (.mclk(mclk), .rstn(rstn), .rx_tok(rx_tok),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_tok(tx_tok), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .reply_dest(reply_dest), .ps_num(ps_num), .ps_resid(ps_resid),
	.ps_we(ps_we), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata));
`default_nettype wire
